//--- hw/cts_pkg.sv
// constants, types and register map for the capture timer start and mode control
package cts_pkg;
   localparam int ADDR_W = 12;
   localparam int IDX_W = 10;
   localparam int CNT_W = 16;

   typedef logic [IDX_W-1:0] cts_idx_type;

   // register indices; byte address is four times the index
   localparam cts_idx_type IDX_STANDBY = 10'h008;
   localparam cts_idx_type IDX_START = 10'h137;
   localparam cts_idx_type IDX_MODE = 10'h138;
   localparam cts_idx_type IDX_WAVE = 10'h139;
   localparam cts_idx_type IDX_CNT0 = 10'h146;
   localparam cts_idx_type IDX_CNT1 = 10'h156;

   // address ranges gated by the standby bits
   localparam cts_idx_type SER_LO = 10'h193;
   localparam cts_idx_type SER_HI = 10'h19d;
   localparam cts_idx_type CAP_LO = 10'h135;
   localparam cts_idx_type CAP_HI = 10'h15f;
   localparam cts_idx_type SEC_LO = 10'h120;
   localparam cts_idx_type SEC_HI = 10'h133;

   // standby register fields
   localparam int STBY_SER_BIT = 3;
   localparam int STBY_CAP_BIT = 4;
   localparam int STBY_SEC_BIT = 5;
   localparam logic [7:0] STBY_RST = 8'h00;
   localparam logic [7:0] STBY_WMASK = 8'h78;
   localparam logic [7:0] STBY_ONES = 8'h00;

   // count start register fields
   localparam int START_RUN_LSB = 0;
   localparam int START_SEL_LSB = 2;
   localparam logic [7:0] START_RST = 8'hf0;
   localparam logic [7:0] START_WMASK = 8'h0f;
   localparam logic [7:0] START_ONES = 8'hf0;

   // mode register fields
   localparam int MODE_SYNC_BIT = 0;
   localparam int MODE_BUF_LSB = 4;
   localparam logic [7:0] MODE_RST = 8'h0e;
   localparam logic [7:0] MODE_WMASK = 8'hf1;
   localparam logic [7:0] MODE_ONES = 8'h0e;

   // waveform mode register fields
   localparam int WAVE_CH0_LSB = 0;
   localparam int WAVE_CH1_LSB = 4;
   localparam logic [7:0] WAVE_RST = 8'h88;
   localparam logic [7:0] WAVE_WMASK = 8'h77;
   localparam logic [7:0] WAVE_ONES = 8'h88;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      RGN_STANDBY, RGN_START, RGN_MODE, RGN_WAVE, RGN_CNT0, RGN_CNT1,
      RGN_EXT, RGN_BLOCKED, RGN_NONE
   } cts_region_type;

   typedef struct packed {
      logic req;
      logic we;
      cts_idx_type idx;
      logic [7:0] wdata;
   } cts_ext_type;

   typedef struct packed {
      logic serial_unit_standby;
      logic capture_timer_standby;
      logic second_timer_standby;
      logic [1:0] chan_count_run;
      logic [1:0] chan_count_op_select;
      logic sync_mode;
      logic [3:0] buffer_select;
      logic [5:0] wave_select;
   } cts_ctrl_type;
endpackage

//--- hw/cts_addr_decode.sv
// register index decoder with standby range blocking
module cts_addr_decode (
   // access
   input wire cts_pkg::cts_idx_type idx,
   input wire logic [7:0] standby,
   // result
   output cts_pkg::cts_region_type region
);
   always_comb begin
      region = cts_pkg::RGN_NONE;
      if (idx == cts_pkg::IDX_STANDBY) begin
         region = cts_pkg::RGN_STANDBY;
      end else if (idx >= cts_pkg::SER_LO && idx <= cts_pkg::SER_HI) begin
         region = standby[cts_pkg::STBY_SER_BIT] ? cts_pkg::RGN_BLOCKED : cts_pkg::RGN_EXT;
      end else if (idx >= cts_pkg::SEC_LO && idx <= cts_pkg::SEC_HI) begin
         region = standby[cts_pkg::STBY_SEC_BIT] ? cts_pkg::RGN_BLOCKED : cts_pkg::RGN_EXT;
      end else if (idx >= cts_pkg::CAP_LO && idx <= cts_pkg::CAP_HI) begin
         if (standby[cts_pkg::STBY_CAP_BIT]) begin
            region = cts_pkg::RGN_BLOCKED;
         end else if (idx == cts_pkg::IDX_START) begin
            region = cts_pkg::RGN_START;
         end else if (idx == cts_pkg::IDX_MODE) begin
            region = cts_pkg::RGN_MODE;
         end else if (idx == cts_pkg::IDX_WAVE) begin
            region = cts_pkg::RGN_WAVE;
         end else if (idx == cts_pkg::IDX_CNT0) begin
            region = cts_pkg::RGN_CNT0;
         end else if (idx == cts_pkg::IDX_CNT1) begin
            region = cts_pkg::RGN_CNT1;
         end
      end
   end
endmodule

//--- hw/cts_count_pair.sv
// two 16-bit channel counters with load and count enable
module cts_count_pair (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // control
   input wire logic [1:0] run,
   input wire logic tick,
   input wire logic hold,
   input wire logic [1:0] load,
   input wire logic [cts_pkg::CNT_W-1:0] load_data,
   // state
   output logic [1:0][cts_pkg::CNT_W-1:0] count
);
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_ch
         always_ff @(posedge core_clk) begin
            if (!rstn) begin
               count[ch] <= 16'h0000;
            end else if (load[ch]) begin
               // a software load beats a count in the same cycle
               count[ch] <= load_data;
            end else if (run[ch] && tick && !hold) begin
               count[ch] <= count[ch] + 16'h0001;
            end
         end
      end
   endgenerate
endmodule

//--- hw/cts_start_mode_ctrl.sv
// capture timer standby, start, mode and waveform registers behind axi4-lite
//
// The AXI4-Lite slave port was left to the implementer.

// Summary of operation
// - serial unit standby bit set blocks all access to its register range
// - capture timer standby bit set blocks all access to its register range
// - second timer standby bit set blocks all access to its register range
// - standby bits 0-2 and 7 read zero; reserved bit 6 written zero
// - start bits 0 and 1 start or stop channel 0 and channel 1
// - start register bits 4-7 read one outside capture timer standby
// - mode bit 0 couples the two counters; resets to zero
// - mode bits 1-3 read one; reset value 0x0e
// - mode bits 4-7 turn general registers into buffers of their partners
// - waveform register bits 3 and 7 read one; reset value 0x88
// - a channel stops only on a zero write with its select bit one
// - with coupling on, a write to either counter loads both
module cts_start_mode_ctrl (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // axi4-lite write address
   input wire logic [cts_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [cts_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // count source enable from the clock select logic
   input wire logic cnt_tick,
   // control to the timers and serial unit
   output cts_pkg::cts_ctrl_type ctrl,
   output logic [cts_pkg::CNT_W-1:0] ch0_count,
   output logic [cts_pkg::CNT_W-1:0] ch1_count,
   // register port to the serial unit and second timer
   output cts_pkg::cts_ext_type ext,
   input wire logic [7:0] ext_rdata
);
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;
   logic aw_full_r;
   logic w_full_r;
   logic ar_full_r;
   logic rd_wait_r;
   cts_pkg::cts_idx_type aw_idx_r;
   cts_pkg::cts_idx_type ar_idx_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic [7:0] stby_r;
   logic [7:0] start_r;
   logic [7:0] mode_r;
   logic [7:0] wave_r;
   logic [7:0] start_nxt;
   cts_pkg::cts_ext_type ext_r;
   cts_pkg::cts_region_type wr_rgn;
   cts_pkg::cts_region_type rd_rgn;
   logic wr_go;
   logic rd_go;
   logic wr_lo;
   logic cnt_sel;
   logic [1:0] cnt_load;
   logic [cts_pkg::CNT_W-1:0] cnt_data;
   logic [1:0][cts_pkg::CNT_W-1:0] count_q;
   logic [31:0] rd_local;
   logic rd_err;

   // one write at a time: a new address or data is not taken until the response is gone
   assign wr_go = aw_full_r && w_full_r && !bvalid_r;
   // write wins the shared register port when both are ready in one cycle
   assign rd_go = ar_full_r && !rd_wait_r && !rvalid_r && !wr_go;
   assign wr_lo = wr_go && w_strb_r[0];

   cts_addr_decode u_wr_dec (
      .idx(aw_idx_r),
      .standby(stby_r),
      .region(wr_rgn)
   );

   cts_addr_decode u_rd_dec (
      .idx(ar_idx_r),
      .standby(stby_r),
      .region(rd_rgn)
   );

   // write address channel
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         awready_r <= 1'b0;
         aw_full_r <= 1'b0;
         aw_idx_r <= '0;
      end else begin
         if (s_axi_awvalid && awready_r) begin
            awready_r <= 1'b0;
            aw_full_r <= 1'b1;
            aw_idx_r <= s_axi_awaddr[cts_pkg::ADDR_W-1:2];
         end else begin
            if (wr_go) begin
               aw_full_r <= 1'b0;
            end
            if (!aw_full_r && !bvalid_r) begin
               awready_r <= 1'b1;
            end
         end
      end
   end

   // write data channel
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         wready_r <= 1'b0;
         w_full_r <= 1'b0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else begin
         if (s_axi_wvalid && wready_r) begin
            wready_r <= 1'b0;
            w_full_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else begin
            if (wr_go) begin
               w_full_r <= 1'b0;
            end
            if (!w_full_r && !bvalid_r) begin
               wready_r <= 1'b1;
            end
         end
      end
   end

   // write response; blocked ranges still answer okay
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         bvalid_r <= 1'b0;
         bresp_r <= cts_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r <= (wr_rgn == cts_pkg::RGN_NONE) ? cts_pkg::RESP_SLVERR : cts_pkg::RESP_OKAY;
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // read address channel
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         arready_r <= 1'b0;
         ar_full_r <= 1'b0;
         ar_idx_r <= '0;
      end else begin
         if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            ar_full_r <= 1'b1;
            ar_idx_r <= s_axi_araddr[cts_pkg::ADDR_W-1:2];
         end else begin
            if (rd_go) begin
               ar_full_r <= 1'b0;
            end
            if (!ar_full_r && !rd_wait_r && !rvalid_r) begin
               arready_r <= 1'b1;
            end
         end
      end
   end

   // read data mux
   always_comb begin
      rd_local = 32'h0000_0000;
      rd_err = 1'b0;
      case (rd_rgn)
         cts_pkg::RGN_STANDBY: rd_local = {24'h00_0000, stby_r};
         cts_pkg::RGN_START: rd_local = {24'h00_0000, start_r};
         cts_pkg::RGN_MODE: rd_local = {24'h00_0000, mode_r};
         cts_pkg::RGN_WAVE: rd_local = {24'h00_0000, wave_r};
         cts_pkg::RGN_CNT0: rd_local = {16'h0000, count_q[0]};
         cts_pkg::RGN_CNT1: rd_local = {16'h0000, count_q[1]};
         cts_pkg::RGN_EXT: rd_local = {24'h00_0000, ext_rdata};
         cts_pkg::RGN_BLOCKED: rd_local = 32'h0000_0000;
         default: rd_err = 1'b1;
      endcase
   end

   // read data channel; fixed two stages so the outside port can answer
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         rd_wait_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= cts_pkg::RESP_OKAY;
      end else begin
         rd_wait_r <= rd_go;
         if (rd_wait_r) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_local;
            rresp_r <= rd_err ? cts_pkg::RESP_SLVERR : cts_pkg::RESP_OKAY;
         end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // outside register port for serial unit and second timer
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         ext_r <= '0;
      end else if (wr_lo && wr_rgn == cts_pkg::RGN_EXT) begin
         ext_r <= '{req: 1'b1, we: 1'b1, idx: aw_idx_r, wdata: w_data_r[7:0]};
      end else if (rd_go && rd_rgn == cts_pkg::RGN_EXT) begin
         ext_r <= '{req: 1'b1, we: 1'b0, idx: ar_idx_r, wdata: 8'h00};
      end else begin
         ext_r.req <= 1'b0;
      end
   end

   // standby register
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         stby_r <= cts_pkg::STBY_RST;
      end else if (wr_lo && wr_rgn == cts_pkg::RGN_STANDBY) begin
         stby_r <= (w_data_r[7:0] & cts_pkg::STBY_WMASK) | cts_pkg::STBY_ONES;
      end
   end

   // start register; a zero with its select bit clear leaves a channel running
   always_comb begin
      start_nxt = (w_data_r[7:0] & cts_pkg::START_WMASK) | cts_pkg::START_ONES;
      for (int ch = 0; ch < 2; ch++) begin
         if (!w_data_r[cts_pkg::START_RUN_LSB + ch] && !w_data_r[cts_pkg::START_SEL_LSB + ch]) begin
            start_nxt[cts_pkg::START_RUN_LSB + ch] = start_r[cts_pkg::START_RUN_LSB + ch];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         start_r <= cts_pkg::START_RST;
      end else if (wr_lo && wr_rgn == cts_pkg::RGN_START) begin
         start_r <= start_nxt;
      end
   end

   // mode register
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         mode_r <= cts_pkg::MODE_RST;
      end else if (wr_lo && wr_rgn == cts_pkg::RGN_MODE) begin
         mode_r <= (w_data_r[7:0] & cts_pkg::MODE_WMASK) | cts_pkg::MODE_ONES;
      end
   end

   // waveform mode register
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         wave_r <= cts_pkg::WAVE_RST;
      end else if (wr_lo && wr_rgn == cts_pkg::RGN_WAVE) begin
         wave_r <= (w_data_r[7:0] & cts_pkg::WAVE_WMASK) | cts_pkg::WAVE_ONES;
      end
   end

   // counter load; byte lanes merge into the addressed counter
   always_comb begin
      cnt_sel = (wr_rgn == cts_pkg::RGN_CNT1);
      cnt_data = count_q[cnt_sel];
      if (w_strb_r[0]) begin
         cnt_data[7:0] = w_data_r[7:0];
      end
      if (w_strb_r[1]) begin
         cnt_data[15:8] = w_data_r[15:8];
      end
      cnt_load = 2'h0;
      if (wr_go && (|w_strb_r[1:0])
          && (wr_rgn == cts_pkg::RGN_CNT0 || wr_rgn == cts_pkg::RGN_CNT1)) begin
         if (mode_r[cts_pkg::MODE_SYNC_BIT]) begin
            cnt_load = 2'h3;
         end else begin
            cnt_load[cnt_sel] = 1'b1;
         end
      end
   end

   // counters freeze while their module clock is stopped
   cts_count_pair u_count (
      .core_clk(core_clk),
      .rstn(rstn),
      .run(start_r[cts_pkg::START_RUN_LSB +: 2]),
      .tick(cnt_tick),
      .hold(stby_r[cts_pkg::STBY_CAP_BIT]),
      .load(cnt_load),
      .load_data(cnt_data),
      .count(count_q)
   );

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;
   assign ext = ext_r;
   assign ch0_count = count_q[0];
   assign ch1_count = count_q[1];

   assign ctrl = '{
      serial_unit_standby: stby_r[cts_pkg::STBY_SER_BIT],
      capture_timer_standby: stby_r[cts_pkg::STBY_CAP_BIT],
      second_timer_standby: stby_r[cts_pkg::STBY_SEC_BIT],
      chan_count_run: start_r[cts_pkg::START_RUN_LSB +: 2],
      chan_count_op_select: start_r[cts_pkg::START_SEL_LSB +: 2],
      sync_mode: mode_r[cts_pkg::MODE_SYNC_BIT],
      buffer_select: mode_r[cts_pkg::MODE_BUF_LSB +: 4],
      wave_select: {wave_r[cts_pkg::WAVE_CH1_LSB +: 3], wave_r[cts_pkg::WAVE_CH0_LSB +: 3]}
   };
endmodule

//--- verif/cts_smc_chk.sv
// bus timing and register-control checks for the start and mode block
module cts_smc_chk (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // timer side
   input wire logic cnt_tick,
   input wire cts_pkg::cts_ctrl_type ctrl,
   input wire logic [cts_pkg::CNT_W-1:0] ch0_count,
   input wire logic [cts_pkg::CNT_W-1:0] ch1_count,
   input wire cts_pkg::cts_ext_type ext
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);

   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[3:4] s_axi_rvalid)
      else $error("read answer late");
   a_ser_blocked: assert property (
      ext.req && ext.idx inside {[cts_pkg::SER_LO:cts_pkg::SER_HI]} |->
      !ctrl.serial_unit_standby) else $error("serial unit reached in standby");
   a_sec_blocked: assert property (
      ext.req && ext.idx inside {[cts_pkg::SEC_LO:cts_pkg::SEC_HI]} |->
      !ctrl.second_timer_standby) else $error("second timer reached in standby");
   a_cap_holds: assert property (ctrl.capture_timer_standby |=>
      $stable(ch0_count) && $stable(ch1_count)) else $error("counter moved in standby");
   a_run_counts: assert property (
      ctrl.chan_count_run[0] && cnt_tick && !ctrl.capture_timer_standby |=>
      $rose(s_axi_bvalid) || ch0_count == $past(ch0_count) + 16'h1)
      else $error("running counter did not step");
   a_stop_holds: assert property (!ctrl.chan_count_run[1] |=>
      $rose(s_axi_bvalid) || $stable(ch1_count)) else $error("stopped counter moved");
   a_stop_sel: assert property ($fell(ctrl.chan_count_run[0]) |->
      ctrl.chan_count_op_select[0]) else $error("stop without select bit");

   cover property (ctrl.sync_mode && $rose(s_axi_bvalid));
   cover property (ext.req && ext.we);
   cover property (s_axi_bvalid && s_axi_bresp == cts_pkg::RESP_SLVERR);
endmodule

bind cts_start_mode_ctrl cts_smc_chk i_chk (.core_clk, .rstn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .cnt_tick, .ctrl,
   .ch0_count, .ch1_count, .ext);

//--- verif/testbench.sv
// self-checking bench for the start and mode control block
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, cnt_tick;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [7:0] ext_rdata;
   logic [15:0] ch0_count, ch1_count, c0;
   cts_pkg::cts_ctrl_type ctrl;
   cts_pkg::cts_ext_type ext;
   int n_mismatch = 0;
   int cmp_count = 0;
   int n_ext = 0;
   int e0;
   cts_pkg::cts_ext_type ext_seen = '0;

   cts_start_mode_ctrl i_dut (.core_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .cnt_tick, .ctrl, .ch0_count, .ch1_count, .ext, .ext_rdata);

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // one-cycle pulse, so each access is seen at exactly one falling edge
   always @(negedge core_clk) begin
      if (ext.req === 1'b1) begin
         n_ext++;
         ext_seen = ext;
      end
   end

   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask

   task automatic hang();
      n_mismatch++;
      $display("unexpected bus wait: expected an answer, seen none");
      test_done();
   endtask

   // outputs only move at rising edges, so the falling edge sees what the edge samples
   task automatic wr(input cts_pkg::cts_idx_type i, input logic [31:0] d);
      logic ha, hw, b;
      b = 1'b0;
      s_axi_awaddr <= {i, 2'b00};
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      for (int n = 0; n < 40 && !b; n++) begin
         @(negedge core_clk);
         ha = s_axi_awready;
         hw = s_axi_wready;
         b = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge core_clk);
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
      end
      if (!b) hang();
   endtask

   task automatic rd_chk(input string nm, input cts_pkg::cts_idx_type i,
                         input logic [31:0] e, input logic [1:0] er = 2'h0);
      logic ha, r;
      r = 1'b0;
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1'b1;
      for (int n = 0; n < 40 && !r; n++) begin
         @(negedge core_clk);
         ha = s_axi_arready;
         r = s_axi_rvalid;
         rd = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge core_clk);
         if (ha) s_axi_arvalid <= 1'b0;
      end
      if (!r) hang();
      chk(nm, e, rd);
      chk("rresp", {30'h0, er}, {30'h0, rs});
   endtask

   initial begin
      rstn = 1'b0;
      cnt_tick = 1'b0;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_awaddr = 12'h0;
      s_axi_araddr = 12'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      ext_rdata = 8'ha5;
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      chk("ctrl", 32'h0, {14'h0, ctrl});
      rd_chk("standby", cts_pkg::IDX_STANDBY, 32'h0);
      rd_chk("start", cts_pkg::IDX_START, 32'hf0);
      rd_chk("mode", cts_pkg::IDX_MODE, 32'h0e);
      rd_chk("wave", cts_pkg::IDX_WAVE, 32'h88);
      wr(cts_pkg::IDX_MODE, 32'hff);
      rd_chk("mode", cts_pkg::IDX_MODE, 32'hff);
      chk("buffer_select", 32'hf, {28'h0, ctrl.buffer_select});
      wr(cts_pkg::IDX_MODE, 32'h0);
      rd_chk("mode", cts_pkg::IDX_MODE, 32'h0e);
      wr(cts_pkg::IDX_WAVE, 32'hff);
      chk("wave_select", 32'h3f, {26'h0, ctrl.wave_select});
      wr(cts_pkg::IDX_WAVE, 32'h0);
      rd_chk("wave", cts_pkg::IDX_WAVE, 32'h88);
      wr(cts_pkg::IDX_START, 32'h0);
      rd_chk("start", cts_pkg::IDX_START, 32'hf0);
      // count source set to the undivided clock before the timer goes to standby
      cnt_tick <= 1'b1;
      // all three units halted before standby; reserved bit 6 kept at zero
      wr(cts_pkg::IDX_STANDBY, 32'hbf);
      rd_chk("standby", cts_pkg::IDX_STANDBY, 32'h38);
      // three standby fields sit at the top of the control word
      chk("standby_out", 32'h7, {29'h0, ctrl[17:15]});
      e0 = n_ext;
      wr(cts_pkg::IDX_MODE, 32'h01);
      chk("bresp", 32'h0, {30'h0, rs});
      wr(cts_pkg::SER_HI, 32'h11);
      wr(cts_pkg::SEC_LO, 32'h22);
      rd_chk("mode", cts_pkg::IDX_MODE, 32'h0);
      rd_chk("serial", cts_pkg::SER_LO, 32'h0);
      rd_chk("second", cts_pkg::SEC_HI, 32'h0);
      chk("ext_req", e0, n_ext);
      wr(cts_pkg::IDX_STANDBY, 32'h0);
      rd_chk("mode", cts_pkg::IDX_MODE, 32'h0e);
      rd_chk("serial", cts_pkg::SER_LO, 32'ha5);
      rd_chk("second", cts_pkg::SEC_HI, 32'ha5);
      chk("ext", {12'h0, 2'b10, cts_pkg::SEC_HI, 8'h00}, {12'h0, ext_seen});
      wr(cts_pkg::SER_HI, 32'h11);
      chk("ext", {12'h0, 2'b11, cts_pkg::SER_HI, 8'h11}, {12'h0, ext_seen});
      chk("ext_req", e0 + 3, n_ext);
      rd_chk("unmapped", 10'h192, 32'h0, cts_pkg::RESP_SLVERR);
      wr(10'h192, 32'h55);
      chk("bresp", {30'h0, cts_pkg::RESP_SLVERR}, {30'h0, rs});
      wr(cts_pkg::IDX_START, 32'h0d);
      chk("start_out", 32'hd, {28'h0, ctrl.chan_count_op_select, ctrl.chan_count_run});
      @(negedge core_clk);
      c0 = ch0_count;
      repeat (10) @(negedge core_clk);
      chk("ch0_count", c0 + 16'ha, ch0_count);
      chk("ch1_count", 32'h0, ch1_count);
      @(posedge core_clk);
      // zero run bit without its select bit must not stop the channel
      wr(cts_pkg::IDX_START, 32'h0);
      chk("run", 32'h1, {30'h0, ctrl.chan_count_run});
      wr(cts_pkg::IDX_START, 32'h0e);
      chk("run", 32'h2, {30'h0, ctrl.chan_count_run});
      // sample away from the rising edge so the counters have settled
      @(negedge core_clk);
      c0 = ch0_count;
      e0 = ch1_count;
      repeat (4) @(negedge core_clk);
      chk("ch0_count", c0, ch0_count);
      chk("ch1_count", e0 + 4, ch1_count);
      @(posedge core_clk);
      wr(cts_pkg::IDX_START, 32'h0c);
      c0 = ch1_count;
      wr(cts_pkg::IDX_CNT0, 32'h1234);
      rd_chk("ch0_count", cts_pkg::IDX_CNT0, 32'h1234);
      chk("ch1_count", c0, ch1_count);
      wr(cts_pkg::IDX_MODE, 32'h01);
      wr(cts_pkg::IDX_CNT1, 32'h00ab);
      chk("ch0_count", 32'hab, ch0_count);
      chk("ch1_count", 32'hab, ch1_count);
      // high byte lane only: both counters keep their low byte
      s_axi_wstrb <= 4'h2;
      wr(cts_pkg::IDX_CNT0, 32'h5600);
      s_axi_wstrb <= 4'hf;
      rd_chk("ch1_count", cts_pkg::IDX_CNT1, 32'h56ab);
      chk("ch0_count", 32'h56ab, ch0_count);
      test_done();
   end
endmodule
